// file: rtl/scp_defines.svh
`ifndef SCP_DEFINES_SVH
`define SCP_DEFINES_SVH
// ==========================================================
// framing of one transfer
// ==========================================================
`define SCP_ADDR_BITS 7
`define SCP_DATA_BITS 8
`define SCP_FRAME_BITS 16
// bit counter value at the last header bit
`define SCP_HDR_LAST 5'h07
// bit counter value at the last frame bit
`define SCP_FRAME_LAST 5'h0f
// first counter value at which a falling edge shifts read data
`define SCP_OUT_SHIFT_FIRST 5'h09
// host side: first bit index that carries read data
`define SCP_RD_FIRST_BIT 4'h8
`define SCP_HOST_LAST_BIT 4'hf
// ==========================================================
// address the host watches for the output level setting
// ==========================================================
`define SCP_LEVEL_ADDR 7'h02
// ==========================================================
// pin index inside the device synchroniser bank
// ==========================================================
`define SCP_PIN_CLK 0
`define SCP_PIN_SEL 1
`define SCP_PIN_DIN 2
`define SCP_PIN_SYNCP 3
`define SCP_PIN_SYNCN 4
`define SCP_PIN_COUNT 5
// ==========================================================
// timing
// ==========================================================
// host clock half period in system clocks
`define SCP_HALF_CYCLES 16
`endif

// file: rtl/scp_pkg.sv
`include "scp_defines.svh"
`default_nettype none
package scp_pkg;
   // ==========================================================
   // data types
   // ==========================================================
   typedef logic [`SCP_ADDR_BITS-1:0] scp_addr_type;
   typedef logic [`SCP_DATA_BITS-1:0] scp_data_type;
   // device framing states, one-hot
   typedef enum logic [5:0] {
      DEV_IDLE = 6'h01,
      DEV_HEADER = 6'h02,
      DEV_WDATA = 6'h04,
      DEV_RLOAD = 6'h08,
      DEV_RDATA = 6'h10,
      DEV_DONE = 6'h20
   } scp_dev_fsm_type;
   // host sequencer states, one-hot
   typedef enum logic [4:0] {
      HST_IDLE = 5'h01,
      HST_LOW = 5'h02,
      HST_HIGH = 5'h04,
      HST_FINISH = 5'h08,
      HST_GAP = 5'h10
   } scp_hst_fsm_type;
   // whole device state
   typedef struct packed {
      logic [`SCP_PIN_COUNT-1:0][2:0] syncPipe;
      logic [`SCP_PIN_COUNT-1:0] pinLvl;
      scp_dev_fsm_type state;
      logic [4:0] bitCnt;
      logic [`SCP_FRAME_BITS-1:0] shiftIn;
      scp_data_type outShift;
      logic sdo;
      logic sdoEn;
      scp_addr_type regAddr;
      scp_data_type regWrData;
      logic wrStrobe;
      logic rdStrobe;
      logic linkSyncRequest;
   } scp_dev_regs_type;
   // whole host state
   typedef struct packed {
      scp_hst_fsm_type state;
      logic [7:0] halfCnt;
      logic [3:0] bitCnt;
      logic [`SCP_FRAME_BITS-1:0] txShift;
      scp_data_type rxShift;
      logic isRead;
      logic isLevelWrite;
      logic levelProgrammed;
      logic [2:0] sdoPipe;
      logic sdoLvl;
      logic selN;
      logic sclk;
      logic mosi;
      logic syncP;
      logic syncN;
      logic ready;
      logic rspValid;
      logic rspRefused;
      scp_data_type rspData;
   } scp_hst_regs_type;
endpackage : scp_pkg
`default_nettype wire

// file: rtl/scp_link_if.sv
`default_nettype none
// ==========================================================
// pins between host controller and configuration port
// ==========================================================
interface scp_link_if;
   logic portSelectN; // active low select
   logic serialClock; // host made serial clock
   logic serialDataIn; // host to device data
   logic serialDataOut; // device output value
   logic serialDataOutEn; // device drives data out
   logic serialDataLine; // resolved output wire
   logic syncReqPos; // differential sync request, plus
   logic syncReqNeg; // differential sync request, minus
   // floating output reads high through the pull-up
   assign serialDataLine = serialDataOutEn ? serialDataOut : 1'b1;
   modport device (
      input portSelectN,
      input serialClock,
      input serialDataIn,
      input syncReqPos,
      input syncReqNeg,
      output serialDataOut,
      output serialDataOutEn
   );
   modport host (
      output portSelectN,
      output serialClock,
      output serialDataIn,
      output syncReqPos,
      output syncReqNeg,
      input serialDataLine
   );
endinterface : scp_link_if
`default_nettype wire

// file: rtl/scp_port_host.sv
`include "scp_defines.svh"
`default_nettype none
// ==========================================================
// host controller end: makes the serial clock by division
// ==========================================================
module scp_port_host #(
   parameter int unsigned HALF_CYCLES = `SCP_HALF_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   scp_link_if.host link,
   input wire logic cmdValid,
   input wire logic cmdRead,
   input wire scp_pkg::scp_addr_type cmdAddr,
   input wire scp_pkg::scp_data_type cmdWrData,
   output logic cmdReady,
   output logic rspValid,
   output logic rspRefused,
   output scp_pkg::scp_data_type rspData,
   output logic levelProgrammed,
   input wire logic linkSyncRequest
);
   import scp_pkg::*;

   localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);

   scp_hst_regs_type s; // current state
   scp_hst_regs_type next_s; // next state
   logic halfDone; // half period elapsed

   // ==========================================================
   // next state
   // ==========================================================
   always_comb begin
      next_s = s;
      next_s.rspValid = 1'b0;
      next_s.rspRefused = 1'b0;
      // data line arrives from another timing domain
      next_s.sdoPipe = {s.sdoPipe[1:0], link.serialDataLine};
      if (s.sdoPipe[1] == s.sdoPipe[2]) begin
         next_s.sdoLvl = s.sdoPipe[2];
      end
      // request high means plus below minus
      next_s.syncP = ~linkSyncRequest;
      next_s.syncN = linkSyncRequest;
      halfDone = (s.halfCnt == HALF_LAST);
      next_s.halfCnt = halfDone ? 8'h00 : s.halfCnt + 8'h01;
      case (s.state)
         HST_IDLE: begin
            next_s.halfCnt = 8'h00;
            if (cmdValid && s.ready) begin
               // reads are refused until the output level is set
               if (cmdRead && !s.levelProgrammed) begin
                  next_s.rspValid = 1'b1;
                  next_s.rspRefused = 1'b1;
               end else begin
                  next_s.txShift = {cmdRead, cmdAddr,
                     cmdRead ? 8'h00 : cmdWrData};
                  next_s.isRead = cmdRead;
                  next_s.isLevelWrite = !cmdRead &&
                     (cmdAddr == `SCP_LEVEL_ADDR);
                  next_s.rxShift = 8'h00;
                  next_s.selN = 1'b0;
                  next_s.mosi = cmdRead;
                  next_s.bitCnt = 4'h0;
                  next_s.ready = 1'b0;
                  next_s.state = HST_LOW;
               end
            end
         end
         HST_LOW: begin
            if (halfDone) begin
               // sample read data just ahead of the rising edge
               if (s.isRead && s.bitCnt >= `SCP_RD_FIRST_BIT) begin
                  next_s.rxShift = {s.rxShift[6:0], s.sdoLvl};
               end
               next_s.sclk = 1'b1;
               next_s.state = HST_HIGH;
            end
         end
         HST_HIGH: begin
            if (halfDone) begin
               next_s.sclk = 1'b0;
               if (s.bitCnt == `SCP_HOST_LAST_BIT) begin
                  next_s.state = HST_FINISH;
               end else begin
                  // data changes on the falling edge only
                  next_s.bitCnt = s.bitCnt + 4'h1;
                  next_s.txShift = {s.txShift[14:0], 1'b0};
                  next_s.mosi = s.txShift[14];
                  next_s.state = HST_LOW;
               end
            end
         end
         HST_FINISH: begin
            if (halfDone) begin
               next_s.selN = 1'b1;
               next_s.rspValid = 1'b1;
               next_s.rspData = s.rxShift;
               if (s.isLevelWrite) begin
                  next_s.levelProgrammed = 1'b1;
               end
               next_s.state = HST_GAP;
            end
         end
         HST_GAP: begin
            // deselected gap lets the device see the high level
            if (halfDone) begin
               next_s.ready = 1'b1;
               next_s.state = HST_IDLE;
            end
         end
         default: begin
            next_s.state = HST_IDLE;
         end
      endcase
   end

   // ==========================================================
   // state register
   // ==========================================================
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s <= '{state: HST_IDLE, halfCnt: 8'h00, bitCnt: 4'h0,
            txShift: 16'h0000, rxShift: 8'h00, isRead: 1'b0,
            isLevelWrite: 1'b0, levelProgrammed: 1'b0,
            sdoPipe: 3'h7, sdoLvl: 1'b1, selN: 1'b1, sclk: 1'b0,
            mosi: 1'b0, syncP: 1'b1, syncN: 1'b0, ready: 1'b1,
            rspValid: 1'b0, rspRefused: 1'b0, rspData: 8'h00};
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================
   // outputs straight from the state register
   // ==========================================================
   assign link.portSelectN = s.selN;
   assign link.serialClock = s.sclk;
   assign link.serialDataIn = s.mosi;
   assign link.syncReqPos = s.syncP;
   assign link.syncReqNeg = s.syncN;
   assign cmdReady = s.ready;
   assign rspValid = s.rspValid;
   assign rspRefused = s.rspRefused;
   assign rspData = s.rspData;
   assign levelProgrammed = s.levelProgrammed;
endmodule // scp_port_host
`default_nettype wire

// file: rtl/scp_port_device.sv
`include "scp_defines.svh"
`default_nettype none
// ==========================================================
// configuration port, device end
// ==========================================================
// frame: one read flag, seven address bits, eight data bits,
// most significant first; data in taken on rising serial
// clock, data out changed on falling serial clock
module scp_port_device (
   input wire logic clk_sys,
   input wire logic rst_b,
   scp_link_if.device link,
   output scp_pkg::scp_addr_type regAddr,
   output scp_pkg::scp_data_type regWrData,
   output logic wrStrobe,
   output logic rdStrobe,
   input wire scp_pkg::scp_data_type readData,
   input wire logic syncSelect,
   input wire logic spiSyncRequest,
   output logic linkSyncRequest
);
   import scp_pkg::*;

   scp_dev_regs_type s; // current state
   scp_dev_regs_type next_s; // next state
   logic [`SCP_PIN_COUNT-1:0] pinRaw; // pins as they arrive
   logic [`SCP_PIN_COUNT-1:0] pinRise; // agreed rising change
   logic [`SCP_PIN_COUNT-1:0] pinFall; // agreed falling change
   logic selected; // port select held low
   logic clkRise; // serial clock rising
   logic clkFall; // serial clock falling
   logic [`SCP_FRAME_BITS-1:0] shifted; // frame after this bit
   logic [4:0] bitNext; // bit count after this bit
   logic pinRequest; // request seen on the pins

   // ==========================================================
   // pin gathering
   // ==========================================================
   // pins are bundled so one loop handles all synchronisers
   assign pinRaw[`SCP_PIN_CLK] = link.serialClock;
   assign pinRaw[`SCP_PIN_SEL] = link.portSelectN;
   assign pinRaw[`SCP_PIN_DIN] = link.serialDataIn;
   assign pinRaw[`SCP_PIN_SYNCP] = link.syncReqPos;
   assign pinRaw[`SCP_PIN_SYNCN] = link.syncReqNeg;

   // ==========================================================
   // change detection per pin
   // ==========================================================
   // a change counts once stages two and three agree; stage one
   // is left to stage two alone so metastability cannot leak
   genvar gi;
   generate
      for (gi = 0; gi < `SCP_PIN_COUNT; gi++) begin : g_edge
         // both late stages high while level still low
         assign pinRise[gi] = s.syncPipe[gi][1] &
            s.syncPipe[gi][2] & ~s.pinLvl[gi];
         // both late stages low while level still high
         assign pinFall[gi] = ~s.syncPipe[gi][1] &
            ~s.syncPipe[gi][2] & s.pinLvl[gi];
      end
   endgenerate

   // low level on the select pin means selected
   assign selected = ~s.pinLvl[`SCP_PIN_SEL];
   // serial clock edges drive all framing
   assign clkRise = pinRise[`SCP_PIN_CLK];
   assign clkFall = pinFall[`SCP_PIN_CLK];

   // ==========================================================
   // next state
   // ==========================================================
   always_comb begin
      next_s = s;
      // strobes last one cycle only
      next_s.wrStrobe = 1'b0;
      next_s.rdStrobe = 1'b0;
      // three stage shift per pin, then agreed level
      for (int i = 0; i < `SCP_PIN_COUNT; i++) begin
         next_s.syncPipe[i] = {s.syncPipe[i][1:0], pinRaw[i]};
         if (s.syncPipe[i][1] == s.syncPipe[i][2]) begin
            next_s.pinLvl[i] = s.syncPipe[i][2];
         end
      end
      // bit taken on this rising edge, from settled data level
      shifted = {s.shiftIn[`SCP_FRAME_BITS-2:0],
         s.pinLvl[`SCP_PIN_DIN]};
      bitNext = s.bitCnt + 5'h01;

      // ---- link sync request routing ----
      // differential pair low when plus sits below minus
      pinRequest = ~s.pinLvl[`SCP_PIN_SYNCP] &
         s.pinLvl[`SCP_PIN_SYNCN];
      // with the select bit set the pins may float, so
      // the pair is not looked at
      if (syncSelect) begin
         next_s.linkSyncRequest = spiSyncRequest;
      end else begin
         next_s.linkSyncRequest = pinRequest;
      end

      // ---- framing ----
      if (!selected) begin
         // deselected: output floats, nothing is shifted in
         next_s.state = DEV_IDLE;
         next_s.sdoEn = 1'b0;
         next_s.bitCnt = 5'h00;
      end else begin
         case (s.state)
            DEV_IDLE: begin
               // fresh selection, partial frames are dropped
               next_s.state = DEV_HEADER;
               next_s.bitCnt = 5'h00;
               next_s.shiftIn = 16'h0000;
               next_s.sdoEn = 1'b0;
               // a rising edge in this very cycle is kept
               if (clkRise) begin
                  next_s.shiftIn = shifted;
                  next_s.bitCnt = bitNext;
               end
            end
            DEV_HEADER: begin
               if (clkRise) begin
                  next_s.shiftIn = shifted;
                  next_s.bitCnt = bitNext;
                  if (s.bitCnt == `SCP_HDR_LAST) begin
                     // header complete: flag and address
                     next_s.regAddr = shifted[6:0];
                     if (shifted[7]) begin
                        next_s.rdStrobe = 1'b1;
                        next_s.state = DEV_RLOAD;
                     end else begin
                        next_s.state = DEV_WDATA;
                     end
                  end
               end
            end
            DEV_WDATA: begin
               if (clkRise) begin
                  next_s.shiftIn = shifted;
                  next_s.bitCnt = bitNext;
                  if (s.bitCnt == `SCP_FRAME_LAST) begin
                     next_s.regWrData = shifted[7:0];
                     next_s.wrStrobe = 1'b1;
                     next_s.state = DEV_DONE;
                  end
               end
            end
            DEV_RLOAD: begin
               // read data is valid in the strobe cycle; the
               // first bit goes out long before the next fall
               next_s.outShift = readData;
               next_s.sdo = readData[7];
               next_s.sdoEn = 1'b1;
               next_s.state = DEV_RDATA;
            end
            DEV_RDATA: begin
               if (clkRise) begin
                  next_s.shiftIn = shifted;
                  next_s.bitCnt = bitNext;
                  if (s.bitCnt == `SCP_FRAME_LAST) begin
                     // read finished, release the output
                     next_s.sdoEn = 1'b0;
                     next_s.state = DEV_DONE;
                  end
               end else if (clkFall &&
                  s.bitCnt >= `SCP_OUT_SHIFT_FIRST) begin
                  // first fall after loading is skipped so the
                  // top bit stands a full serial period
                  next_s.outShift = {s.outShift[6:0], 1'b0};
                  next_s.sdo = s.outShift[6];
               end
            end
            DEV_DONE: begin
               // extra clocks until deselect are ignored
               next_s.sdoEn = 1'b0;
            end
            default: begin
               next_s.state = DEV_IDLE;
               next_s.sdoEn = 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // state register
   // ==========================================================
   // pipes reset to each pin's idle level: select high, sync
   // pair idle, clock and data low, so no false edge follows
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s <= '{syncPipe: 15'h0e38, pinLvl: 5'h0a,
            state: DEV_IDLE, bitCnt: 5'h00, shiftIn: 16'h0000,
            outShift: 8'h00, sdo: 1'b0, sdoEn: 1'b0,
            regAddr: 7'h00, regWrData: 8'h00, wrStrobe: 1'b0,
            rdStrobe: 1'b0, linkSyncRequest: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================
   // outputs straight from the state register
   // ==========================================================
   assign link.serialDataOut = s.sdo;
   assign link.serialDataOutEn = s.sdoEn;
   assign regAddr = s.regAddr;
   assign regWrData = s.regWrData;
   assign wrStrobe = s.wrStrobe;
   assign rdStrobe = s.rdStrobe;
   assign linkSyncRequest = s.linkSyncRequest;
endmodule // scp_port_device
`default_nettype wire

// file: tb/scp_link_checker.sv
`default_nettype none
// ==========================================================
// pin checker for the host to device link
// ==========================================================
module scp_link_checker #(
   parameter int unsigned HALF_CYCLES = 16
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic portSelectN,
   input wire logic serialClock,
   input wire logic serialDataIn,
   input wire logic serialDataOut,
   input wire logic serialDataOutEn,
   input wire logic serialDataLine,
   input wire logic syncReqPos,
   input wire logic syncReqNeg
);
   logic [7:0] highCnt; // cycles the clock stood high
   logic [4:0] riseCnt; // rises in this selection
   logic prevClk; // clock one cycle ago
   logic rdFlag; // first bit of the frame
   // ==========================================================
   // helper counters
   // ==========================================================
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         highCnt <= 8'h00;
         riseCnt <= 5'h00;
         prevClk <= 1'b0;
         rdFlag <= 1'b0;
      end else begin
         highCnt <= serialClock ? highCnt + 8'h01 : 8'h00;
         prevClk <= serialClock;
         // deselect clears the count: frames never carry over
         if (portSelectN) begin
            riseCnt <= 5'h00;
         end else if (serialClock && !prevClk) begin
            riseCnt <= riseCnt + 5'h01;
            if (riseCnt == 5'h00) begin
               rdFlag <= serialDataIn;
            end
         end
      end
   end
   // ==========================================================
   // assertions
   // ==========================================================
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   // select high long enough for the device to see it
   sequence sDeselected;
      portSelectN [*6];
   endsequence
   // clock held low while the device wakes up
   sequence sClockLow;
      !serialClock [*8];
   endsequence
   a_float_when_idle: assert property (sDeselected |->
      !serialDataOutEn && serialDataLine) else $error("driven while idle");
   a_select_before_clock: assert property (
      $fell(portSelectN) |-> sClockLow) else $error("clock at select");
   a_clock_half_period: assert property (
      $fell(serialClock) |-> highCnt == HALF_CYCLES)
      else $error("clock high time off");
   a_frame_sixteen_pulses: assert property (
      $rose(portSelectN) |-> riseCnt == 5'h10) else $error("pulse count");
   a_drive_on_read: assert property ($rose(serialDataOutEn) |->
      !portSelectN && rdFlag && riseCnt == 5'h08) else $error("early drive");
   a_release_at_end: assert property ($fell(serialDataOutEn) |->
      !portSelectN && riseCnt == 5'h10) else $error("late release");
   a_shift_clock_low: assert property (serialDataOutEn &&
      $past(serialDataOutEn) && $changed(serialDataOut) |-> !serialClock)
      else $error("output moved while clock high");
   a_sync_pins_differ: assert property (
      syncReqPos != syncReqNeg) else $error("sync pins equal");
endmodule // scp_link_checker
`default_nettype wire

// file: tb/tb_spi_config_port_sync_select.sv
`include "scp_defines.svh"
`default_nettype none
// ==========================================================
// bench: host and device ends, plus a misbehaving host
// ==========================================================
module tb_spi_config_port_sync_select;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HALF = 16; // serial half period in clocks
   localparam int LINK_HALF = 4; // bench link clock, 200 ns period
   int failures, checks, nWr, nRd, nWr2, nSel; // tallies
   logic clk_sys, rst_b, cmdValid, cmdRead, cmdReady, rspValid;
   logic rspRefused, levelProgrammed, hostSync, syncSelect;
   logic spiSyncRequest, wrStrobe, rdStrobe, wrStrobe2, devSync, devSync2;
   scp_pkg::scp_addr_type cmdAddr, regAddr, regAddr2;
   scp_pkg::scp_data_type cmdWrData, rspData, regWrData, regWrData2;
   scp_pkg::scp_data_type readData;
   scp_link_if lnk(); // link between the two design ends
   scp_link_if lnk2(); // bench plays the host here
   scp_port_host #(.HALF_CYCLES(HALF)) u_scp_port_host (.clk_sys, .rst_b,
      .link(lnk.host), .cmdValid, .cmdRead, .cmdAddr, .cmdWrData,
      .cmdReady, .rspValid, .rspRefused, .rspData, .levelProgrammed,
      .linkSyncRequest(hostSync));
   scp_port_device u_scp_port_device (.clk_sys, .rst_b, .link(lnk.device),
      .regAddr, .regWrData, .wrStrobe, .rdStrobe, .readData, .syncSelect,
      .spiSyncRequest, .linkSyncRequest(devSync));
   scp_port_device u_scp_port_device_b (.clk_sys, .rst_b,
      .link(lnk2.device), .regAddr(regAddr2), .regWrData(regWrData2),
      .wrStrobe(wrStrobe2), .rdStrobe(), .readData, .syncSelect,
      .spiSyncRequest, .linkSyncRequest(devSync2));
   scp_link_checker #(.HALF_CYCLES(HALF)) u_scp_link_checker (.clk_sys,
      .rst_b, .portSelectN(lnk.portSelectN),
      .serialClock(lnk.serialClock), .serialDataIn(lnk.serialDataIn),
      .serialDataOut(lnk.serialDataOut),
      .serialDataOutEn(lnk.serialDataOutEn),
      .serialDataLine(lnk.serialDataLine), .syncReqPos(lnk.syncReqPos),
      .syncReqNeg(lnk.syncReqNeg));
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // strobes last one cycle, so tally them mid-cycle
   always @(negedge clk_sys) begin
      nWr += int'(wrStrobe === 1'b1);
      nRd += int'(rdStrobe === 1'b1);
      nWr2 += int'(wrStrobe2 === 1'b1);
      nSel += int'(lnk.portSelectN === 1'b0);
   end
   // ==========================================================
   // compare, verdict, bus tasks
   // ==========================================================
   task automatic chk(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // one host command, entered at a falling edge
   task automatic cmd(input logic rd, input logic [6:0] a,
      input logic [7:0] d, output logic rf, output logic [7:0] q);
      int n;
      for (n = 0; n < 2000 && cmdReady !== 1'b1; n++) @(negedge clk_sys);
      {cmdValid, cmdRead, cmdAddr, cmdWrData} = {1'b1, rd, a, d};
      @(negedge clk_sys);
      cmdValid = 1'b0;
      for (n = 0; n < 2000 && rspValid !== 1'b1; n++) @(negedge clk_sys);
      rf = rspRefused;
      q = rspData;
      failures += int'(n >= 2000); // no answer in time
   endtask
   // nb bits of f on the second link, msb first
   task automatic frame2(input logic [15:0] f, input int nb,
      input logic selN);
      lnk2.portSelectN = selN;
      for (int i = 15; i > 15 - nb; i--) begin
         lnk2.serialDataIn = f[i];
         repeat (LINK_HALF) @(negedge clk_sys);
         lnk2.serialClock = 1'b1;
         repeat (LINK_HALF) @(negedge clk_sys);
         lnk2.serialClock = 1'b0;
      end
      repeat (LINK_HALF) @(negedge clk_sys);
      lnk2.portSelectN = 1'b1;
      // released data wire shows the opposite of its last bit
      lnk2.serialDataIn = ~lnk2.serialDataIn;
      repeat (LINK_HALF) @(negedge clk_sys);
   endtask
   // ==========================================================
   // scenarios
   // ==========================================================
   task automatic tRefuse;
      logic rf;
      logic [7:0] q;
      int s0;
      s0 = nSel;
      cmd(1'b1, 7'h11, 8'h00, rf, q);
      chk("refused", rf, 1'b1);
      chk("link quiet", 16'(nSel - s0), 16'h0);
   endtask
   task automatic tWrite;
      logic rf;
      logic [7:0] q;
      int w0;
      w0 = nWr;
      cmd(1'b0, `SCP_LEVEL_ADDR, 8'ha5, rf, q);
      chk("write refused", rf, 1'b0);
      chk("level set", levelProgrammed, 1'b1);
      chk("write strobes", 16'(nWr - w0), 16'h1);
      chk("write addr", regAddr, `SCP_LEVEL_ADDR);
      chk("write data", regWrData, 8'ha5);
   endtask
   // two reads back to back with mirrored patterns
   task automatic tRead;
      logic rf;
      logic [7:0] q;
      logic [7:0] pat [2] = '{8'h3c, 8'hc3};
      int r0;
      foreach (pat[i]) begin
         readData = pat[i];
         r0 = nRd;
         cmd(1'b1, 7'h55 ^ 7'(i), 8'h00, rf, q);
         chk("read data", q, pat[i]);
         chk("read strobes", 16'(nRd - r0), 16'h1);
         chk("read addr", regAddr, 7'h55 ^ 7'(i));
         chk("line floats", lnk.serialDataLine, 1'b1);
      end
   endtask
   // clocking while idle, a cut frame, then a whole frame
   task automatic tAbort;
      int w0;
      w0 = nWr2;
      frame2(16'h0a69, 16, 1'b1);
      chk("idle frame", 16'(nWr2 - w0), 16'h0);
      frame2(16'hffff, 5, 1'b0);
      chk("short frame", 16'(nWr2 - w0), 16'h0);
      frame2(16'h0a69, 16, 1'b0);
      chk("restart strobes", 16'(nWr2 - w0), 16'h1);
      chk("restart addr", regAddr2, 7'h0a);
      chk("restart data", regWrData2, 8'h69);
      chk("out off", lnk2.serialDataOutEn, 1'b0);
   endtask
   // every mix of source select, pin request and port request
   task automatic tSync;
      logic [2:0] v;
      for (int i = 0; i < 8; i++) begin
         v = 3'(i);
         {syncSelect, hostSync, spiSyncRequest} = v;
         {lnk2.syncReqPos, lnk2.syncReqNeg} = {~v[1], v[1]};
         repeat (10) @(negedge clk_sys);
         chk("sync", devSync, v[2] ? v[0] : v[1]);
         chk("sync pins", devSync2, v[2] ? v[0] : v[1]);
      end
   endtask
   initial begin
      rst_b = 1'b0;
      {cmdValid, cmdRead, cmdAddr, cmdWrData} = '0;
      {hostSync, syncSelect, spiSyncRequest} = 3'h0;
      readData = 8'h00;
      {lnk2.portSelectN, lnk2.serialClock, lnk2.serialDataIn} = 3'h4;
      {lnk2.syncReqPos, lnk2.syncReqNeg} = 2'h2;
      repeat (12) @(negedge clk_sys);
      rst_b = 1'b1;
      repeat (6) @(negedge clk_sys);
      tRefuse();
      tWrite();
      tRead();
      tAbort();
      tSync();
      print_verdict();
   end
   // watchdog: the run needs some 2100 cycles
   initial begin
      repeat (40000) @(posedge clk_sys);
      failures++;
      print_verdict();
   end
endmodule // tb_spi_config_port_sync_select
`default_nettype wire
